//--- rtl/mci_pkg.sv
// Constants, types and register map for the mode report and idle timer block
package mci_pkg;

    // Clock and timer base
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int CYCLES_PER_MS = CLK_FREQ_HZ / 1000;
    localparam int TIMER_UNIT_MS = 5;
    localparam int TIMER_UNIT_CYCLES = TIMER_UNIT_MS * CYCLES_PER_MS;
    localparam int DEFAULT_SLEEP_MS = 20;
    localparam int DEFAULT_SLEEP_UNITS = DEFAULT_SLEEP_MS / TIMER_UNIT_MS;
    localparam int CMD_BUSY_CYCLES = 2;

    // APB register map
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_COMMAND = 12'h000;
    localparam logic [11:0] OFF_DRIVE_HEAD = 12'h004;
    localparam logic [11:0] OFF_XFER_COUNT = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00C;
    localparam logic [11:0] OFF_CONFIG = 12'h010;
    localparam logic [11:0] OFF_WORD88 = 12'h014;
    localparam logic [11:0] OFF_WORD160 = 12'h018;
    localparam logic [11:0] OFF_WORD163 = 12'h01C;
    localparam logic [11:0] OFF_WORD164 = 12'h020;

    // Opcodes of the idle command
    localparam logic [7:0] OP_IDLE_A = 8'h97;
    localparam logic [7:0] OP_IDLE_B = 8'hE3;

    // Status register bits
    localparam int ST_BUSY = 0;
    localparam int ST_INTRQ = 1;
    localparam int ST_IDLE = 2;
    localparam int ST_SLEEP = 3;
    localparam int ST_AUTOPD = 4;
    localparam int ST_IDLE_SEEN = 5;

    // Identification word fields
    localparam int W88_SUP_LSB = 0;
    localparam int W88_SEL_LSB = 8;
    localparam int W160_VLD_BIT = 15;
    localparam int W160_NOXP_BIT = 13;
    localparam int W160_XE_BIT = 12;
    localparam int W160_CUR_LSB = 0;
    localparam int W163_PIO_SUP_LSB = 0;
    localparam int W163_MDMA_SUP_LSB = 3;
    localparam int W163_PIO_SEL_LSB = 6;
    localparam int W163_MDMA_SEL_LSB = 9;
    localparam int W164_IO_LSB = 0;
    localparam int W164_MEM_LSB = 3;
    localparam int W164_IO_UDMA_LSB = 6;
    localparam int W164_MEM_UDMA_LSB = 9;
    localparam int W164_SEL_LSB = 12;
    localparam int W164_UDMA_BIT = 15;
    localparam logic [2:0] UDMA_MODE_LIMIT = 3'h6;

    // Mode selection kinds
    typedef enum logic [1:0] {
        MCI_DMA_NONE,
        MCI_DMA_UDMA,
        MCI_DMA_MDMA
    } mci_dma_kind_t;

    // Configuration register layout, bit 9 downward
    typedef struct packed {
        logic [2:0] pio_sel;
        logic [2:0] dma_mode;
        logic [1:0] dma_kind;
        logic l1_dis;
        logic true_ide;
    } mci_cfg_t;

    localparam logic [9:0] CFG_RESET = 10'h001;

    // Power states
    typedef enum logic [1:0] {
        MCI_PM_ACTIVE,
        MCI_PM_BUSY,
        MCI_PM_IDLE,
        MCI_PM_SLEEP
    } mci_pm_state_t;

endpackage

//--- rtl/mci_mode_idle.sv
// APB slave reporting transfer-mode words and running the idle power-down timer
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps

module mci_mode_idle #(
    parameter int TIMER_UNIT_CYC = mci_pkg::TIMER_UNIT_CYCLES,
    parameter int BUSY_CYC = mci_pkg::CMD_BUSY_CYCLES,
    parameter bit UDMA_SUPPORTED = 1'b1,
    parameter logic [2:0] UDMA_MAX = 3'h4,
    parameter logic [2:0] PIO_ADV_MAX = 3'h2,
    parameter logic [2:0] MDMA_ADV_MAX = 3'h2,
    parameter logic [2:0] PCC_IO_MODE = 3'h0,
    parameter logic [2:0] PCC_MEM_MODE = 3'h0,
    parameter bit PCC_UDMA_SUPPORTED = 1'b0,
    parameter logic [2:0] PCC_IO_UDMA_MAX = 3'h0,
    parameter logic [2:0] PCC_MEM_UDMA_MAX = 3'h0,
    parameter bit POWER_DESC_VALID = 1'b1,
    parameter bit NO_LEVEL1_CMDS = 1'b0,
    parameter logic [11:0] MAX_CURRENT_MA = 12'h064
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device status
    output logic busy_flag,
    output logic host_intrq,
    output logic idle_mode,
    output logic sleep_mode
);

    localparam int TW = $clog2(TIMER_UNIT_CYC + 1);
    localparam int BW = $clog2(BUSY_CYC + 1);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [2:0] clamp_code(input logic [2:0] code, input logic [2:0] lim);
        clamp_code = (code <= lim) ? code : 3'h0;
    endfunction

    function automatic logic is_idle_op(input logic [7:0] op);
        is_idle_op = (op == mci_pkg::OP_IDLE_A) || (op == mci_pkg::OP_IDLE_B);
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        unique case (a)
            mci_pkg::OFF_COMMAND, mci_pkg::OFF_DRIVE_HEAD, mci_pkg::OFF_XFER_COUNT,
            mci_pkg::OFF_STATUS, mci_pkg::OFF_CONFIG, mci_pkg::OFF_WORD88,
            mci_pkg::OFF_WORD160, mci_pkg::OFF_WORD163, mci_pkg::OFF_WORD164:
                is_mapped = 1'b1;
            default:
                is_mapped = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    mci_pkg::mci_cfg_t cfg_q, cfg_d;
    mci_pkg::mci_pm_state_t pm_q, pm_d;
    logic [7:0] drive_head_q, drive_head_d;
    logic [7:0] xfer_cnt_q, xfer_cnt_d;
    logic [7:0] cmd_cnt_q, cmd_cnt_d;
    logic [7:0] units_q, units_d;
    logic [7:0] units_left_q, units_left_d;
    logic [TW-1:0] tick_q, tick_d;
    logic [BW-1:0] busy_cnt_q, busy_cnt_d;
    logic intrq_q, intrq_d;
    logic autopd_q, autopd_d;
    logic idle_seen_q, idle_seen_d;
    logic [31:0] prdata_q, prdata_d;

    logic setup_ph, acc_wr, acc_rd, cmd_go;
    logic [15:0] word88, word160, word163, word164;
    logic [31:0] status_word;
    mci_pkg::mci_dma_kind_t kind;
    logic [6:0] udma_sup;

    assign setup_ph = psel && !penable;
    assign acc_wr = psel && penable && pwrite;
    assign acc_rd = psel && penable && !pwrite;
    assign kind = (cfg_q.dma_kind == mci_pkg::MCI_DMA_UDMA) ? mci_pkg::MCI_DMA_UDMA :
                  (cfg_q.dma_kind == mci_pkg::MCI_DMA_MDMA) ? mci_pkg::MCI_DMA_MDMA :
                  mci_pkg::MCI_DMA_NONE;

    ////////////////////////////////////////////////////////////////////////
    // Identification words

    always_comb begin
        for (int i = 0; i < 7; i++) begin
            udma_sup[i] = (3'(i) <= UDMA_MAX);
        end
        word88 = 16'h0000;
        if (cfg_q.true_ide && UDMA_SUPPORTED) begin
            word88[mci_pkg::W88_SUP_LSB +: 7] = udma_sup;
            if (kind == mci_pkg::MCI_DMA_UDMA && cfg_q.dma_mode <= UDMA_MAX) begin
                word88[mci_pkg::W88_SEL_LSB + int'(cfg_q.dma_mode)] = 1'b1;
            end
        end

        word160 = 16'h0000;
        word160[mci_pkg::W160_VLD_BIT] = POWER_DESC_VALID;
        word160[mci_pkg::W160_NOXP_BIT] = NO_LEVEL1_CMDS;
        word160[mci_pkg::W160_XE_BIT] = NO_LEVEL1_CMDS || cfg_q.l1_dis;
        word160[mci_pkg::W160_CUR_LSB +: 12] = MAX_CURRENT_MA;

        word163 = 16'h0000;
        word163[mci_pkg::W163_PIO_SUP_LSB +: 3] = PIO_ADV_MAX;
        word163[mci_pkg::W163_MDMA_SUP_LSB +: 3] = MDMA_ADV_MAX;
        word163[mci_pkg::W163_PIO_SEL_LSB +: 3] = clamp_code(cfg_q.pio_sel, PIO_ADV_MAX);
        if (kind == mci_pkg::MCI_DMA_MDMA) begin
            word163[mci_pkg::W163_MDMA_SEL_LSB +: 3] = clamp_code(cfg_q.dma_mode,
                                                                  MDMA_ADV_MAX);
        end

        word164 = 16'h0000;
        word164[mci_pkg::W164_IO_LSB +: 3] = PCC_IO_MODE;
        word164[mci_pkg::W164_MEM_LSB +: 3] = PCC_MEM_MODE;
        word164[mci_pkg::W164_UDMA_BIT] = PCC_UDMA_SUPPORTED;
        if (PCC_UDMA_SUPPORTED) begin
            word164[mci_pkg::W164_IO_UDMA_LSB +: 3] = PCC_IO_UDMA_MAX;
            word164[mci_pkg::W164_MEM_UDMA_LSB +: 3] = PCC_MEM_UDMA_MAX;
            if (kind == mci_pkg::MCI_DMA_UDMA) begin
                word164[mci_pkg::W164_SEL_LSB +: 3] = clamp_code(cfg_q.dma_mode,
                                                                 mci_pkg::UDMA_MODE_LIMIT);
            end
        end

    end

    ////////////////////////////////////////////////////////////////////////
    // Status word

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[mci_pkg::ST_BUSY] = (pm_q == mci_pkg::MCI_PM_BUSY);
        status_word[mci_pkg::ST_INTRQ] = intrq_q;
        status_word[mci_pkg::ST_IDLE] = (pm_q == mci_pkg::MCI_PM_IDLE);
        status_word[mci_pkg::ST_SLEEP] = (pm_q == mci_pkg::MCI_PM_SLEEP);
        status_word[mci_pkg::ST_AUTOPD] = autopd_q;
        status_word[mci_pkg::ST_IDLE_SEEN] = idle_seen_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file next state

    always_comb begin
        cfg_d = cfg_q;
        drive_head_d = drive_head_q;
        xfer_cnt_d = xfer_cnt_q;
        prdata_d = prdata_q;

        // Read data captured in the setup phase
        if (setup_ph && !pwrite) begin
            unique case (paddr)
                mci_pkg::OFF_DRIVE_HEAD: prdata_d = {24'h00_0000, drive_head_q};
                mci_pkg::OFF_XFER_COUNT: prdata_d = {24'h00_0000, xfer_cnt_q};
                mci_pkg::OFF_STATUS: prdata_d = status_word;
                mci_pkg::OFF_CONFIG: prdata_d = {22'h00_0000, cfg_q};
                mci_pkg::OFF_WORD88: prdata_d = {16'h0000, word88};
                mci_pkg::OFF_WORD160: prdata_d = {16'h0000, word160};
                mci_pkg::OFF_WORD163: prdata_d = {16'h0000, word163};
                mci_pkg::OFF_WORD164: prdata_d = {16'h0000, word164};
                default: prdata_d = 32'h0000_0000;
            endcase
        end

        // Register writes, task file locked while busy
        if (acc_wr && pm_q != mci_pkg::MCI_PM_BUSY) begin
            unique case (paddr)
                mci_pkg::OFF_DRIVE_HEAD: drive_head_d = pwdata[7:0];
                mci_pkg::OFF_XFER_COUNT: xfer_cnt_d = pwdata[7:0];
                mci_pkg::OFF_CONFIG: cfg_d = pwdata[9:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command and power next state

    assign cmd_go = acc_wr && (pm_q != mci_pkg::MCI_PM_BUSY) &&
                    (paddr == mci_pkg::OFF_COMMAND) && is_idle_op(pwdata[7:0]);

    always_comb begin
        pm_d = pm_q;
        cmd_cnt_d = cmd_cnt_q;
        units_d = units_q;
        units_left_d = units_left_q;
        tick_d = tick_q;
        busy_cnt_d = busy_cnt_q;
        intrq_d = intrq_q;
        autopd_d = autopd_q;
        idle_seen_d = idle_seen_q;

        // Status read acknowledges the interrupt
        if (acc_rd && paddr == mci_pkg::OFF_STATUS) begin
            intrq_d = 1'b0;
        end

        // Power state and timer
        unique case (pm_q)
            mci_pkg::MCI_PM_BUSY: begin
                tick_d = '0;
                if (busy_cnt_q == '0) begin
                    pm_d = mci_pkg::MCI_PM_IDLE;
                    intrq_d = 1'b1;
                    idle_seen_d = 1'b1;
                    if (cmd_cnt_q != 8'h00) begin
                        autopd_d = 1'b1;
                        units_d = cmd_cnt_q;
                        units_left_d = cmd_cnt_q;
                    end else begin
                        autopd_d = 1'b0;
                    end
                end else begin
                    busy_cnt_d = busy_cnt_q - BW'(1);
                end
            end
            mci_pkg::MCI_PM_SLEEP: begin
                tick_d = '0;
                if (setup_ph) begin
                    pm_d = mci_pkg::MCI_PM_ACTIVE;
                    units_left_d = units_q;
                end
            end
            mci_pkg::MCI_PM_ACTIVE, mci_pkg::MCI_PM_IDLE: begin
                if (setup_ph || !autopd_q) begin
                    tick_d = '0;
                    units_left_d = units_q;
                end else if (tick_q == TW'(TIMER_UNIT_CYC - 1)) begin
                    tick_d = '0;
                    if (units_left_q <= 8'h01) begin
                        pm_d = mci_pkg::MCI_PM_SLEEP;
                    end else begin
                        units_left_d = units_left_q - 8'h01;
                    end
                end else begin
                    tick_d = tick_q + TW'(1);
                end
            end
        endcase

        // Idle opcode accepted, wins over a same-cycle timer expiry
        if (cmd_go) begin
            pm_d = mci_pkg::MCI_PM_BUSY;
            cmd_cnt_d = xfer_cnt_q;
            busy_cnt_d = BW'(BUSY_CYC - 1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= mci_pkg::CFG_RESET;
            drive_head_q <= 8'h00;
            xfer_cnt_q <= 8'h00;
            prdata_q <= 32'h0000_0000;
        end else begin
            cfg_q <= cfg_d;
            drive_head_q <= drive_head_d;
            xfer_cnt_q <= xfer_cnt_d;
            prdata_q <= prdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_q <= mci_pkg::MCI_PM_ACTIVE;
            cmd_cnt_q <= 8'h00;
            units_q <= 8'(mci_pkg::DEFAULT_SLEEP_UNITS);
            units_left_q <= 8'(mci_pkg::DEFAULT_SLEEP_UNITS);
            tick_q <= '0;
            busy_cnt_q <= '0;
            intrq_q <= 1'b0;
            autopd_q <= 1'b1;
            idle_seen_q <= 1'b0;
        end else begin
            pm_q <= pm_d;
            cmd_cnt_q <= cmd_cnt_d;
            units_q <= units_d;
            units_left_q <= units_left_d;
            tick_q <= tick_d;
            busy_cnt_q <= busy_cnt_d;
            intrq_q <= intrq_d;
            autopd_q <= autopd_d;
            idle_seen_q <= idle_seen_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign busy_flag = (pm_q == mci_pkg::MCI_PM_BUSY);
    assign host_intrq = intrq_q;
    assign idle_mode = (pm_q == mci_pkg::MCI_PM_IDLE);
    assign sleep_mode = (pm_q == mci_pkg::MCI_PM_SLEEP);

endmodule

//--- test/mci_mode_idle_props.sv
// Checker of the mode report and idle timer block
`timescale 1ns/1ps
module mci_mode_idle_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Status
    input wire logic busy_flag,
    input wire logic host_intrq,
    input wire logic idle_mode,
    input wire logic sleep_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic cmd_wr;
    logic op_idle;
    logic acc_rd;
    assign cmd_wr = psel && penable && pwrite && paddr == mci_pkg::OFF_COMMAND && !busy_flag;
    assign op_idle = pwdata[7:0] == mci_pkg::OP_IDLE_A || pwdata[7:0] == mci_pkg::OP_IDLE_B;
    assign acc_rd = psel && penable && !pwrite;
    ////////////////////////////////////////////////////////////////////////////
    // Idle command steps
    sequence s_busy_run;
        busy_flag [*2];
    endsequence
    sequence s_done;
        !busy_flag && host_intrq && idle_mode;
    endsequence
    a_idle_start: assert property (cmd_wr && op_idle |=> busy_flag)
        else $error("idle opcode did not raise busy");
    a_other_op: assert property (cmd_wr && !op_idle |=> !busy_flag)
        else $error("other opcode raised busy");
    a_idle_steps: assert property ($rose(busy_flag) |-> s_busy_run ##1 s_done)
        else $error("idle command steps wrong");
    a_sleep_wake: assert property (psel && !penable && sleep_mode |=> !sleep_mode)
        else $error("access did not wake");
    ////////////////////////////////////////////////////////////////////////////
    // Identification words
    a_udma_onehot: assert property (acc_rd && paddr == mci_pkg::OFF_WORD88
        |-> $onehot0(prdata[15:8]))
        else $error("several modes selected");
    a_udma_spare: assert property (acc_rd && paddr == mci_pkg::OFF_WORD88
        |-> !prdata[15] && !prdata[7])
        else $error("word88 reserved bit set");
    a_udma_cumul: assert property (acc_rd && paddr == mci_pkg::OFF_WORD88
        |-> ((prdata[6:0] + 7'h01) & prdata[6:0]) == 7'h00)
        else $error("support bits not cumulative");
    a_pwr_spare: assert property (acc_rd && paddr == mci_pkg::OFF_WORD160 |-> !prdata[14])
        else $error("word160 bit 14 set");
    a_adv_spare: assert property (acc_rd && paddr == mci_pkg::OFF_WORD163
        |-> prdata[15:12] == 4'h0)
        else $error("word163 reserved bits set");
endmodule

bind mci_mode_idle mci_mode_idle_props i_mci_mode_idle_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy_flag(busy_flag),
    .host_intrq(host_intrq), .idle_mode(idle_mode), .sleep_mode(sleep_mode));

//--- test/mci_host_model.sv
// Host-side APB master model issuing task-file and register accesses
`timescale 1ns/1ps
module mci_host_model (
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // Setup, access until pready, then release
    task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= we;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

//--- test/test_mci_mode_idle.sv
// Self-checking bench of the mode report and idle timer block
`timescale 1ns/1ps
module test_mci_mode_idle;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic busy_flag, host_intrq, idle_mode, sleep_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    mci_mode_idle #(.TIMER_UNIT_CYC(20), .PCC_IO_MODE(3'h3),
        .PCC_UDMA_SUPPORTED(1'b1), .PCC_IO_UDMA_MAX(3'h6), .PCC_MEM_UDMA_MAX(3'h5))
    i_mci_mode_idle (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy_flag(busy_flag), .host_intrq(host_intrq),
        .idle_mode(idle_mode), .sleep_mode(sleep_mode));
    mci_host_model i_mci_host_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_mci_host_model.xfer(1'b1, a, d, rdv, err);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string name);
        i_mci_host_model.xfer(1'b0, a, 32'h0000_0000, rdv, err);
        chk(name, rdv, exp);
    endtask
    task automatic cs(input string name, input logic [31:0] exp);
        chk(name, {31'h0, sleep_mode}, exp);
    endtask
    task automatic wait_done();
        int n = 0;
        while (host_intrq !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        chk("intrq", {31'h0, host_intrq}, 32'h0000_0001);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rc(mci_pkg::OFF_CONFIG, 32'h0000_0001, "config");
        rc(mci_pkg::OFF_STATUS, 32'h0000_0010, "status");
        repeat (74) @(posedge pclk);
        cs("awake", 32'h0000_0000);
        repeat (8) @(posedge pclk);
        cs("asleep", 32'h0000_0001);
        rc(mci_pkg::OFF_WORD160, 32'h0000_8064, "word160");
        wr(mci_pkg::OFF_CONFIG, 32'h0000_0003);
        rc(mci_pkg::OFF_WORD160, 32'h0000_9064, "word160 dis");
        for (int m = 0; m < 7; m++) begin
            wr(mci_pkg::OFF_CONFIG, 32'h0000_0005 | (32'(m) << 4));
            rc(mci_pkg::OFF_WORD88, 32'h0000_001F | ((m <= 4) ? (32'h0000_0001 << (8 + m))
                : 32'h0000_0000), "word88");
            rc(mci_pkg::OFF_WORD164, 32'h0000_8B83 | (32'(m) << 12), "word164");
        end
        wr(mci_pkg::OFF_CONFIG, 32'h0000_0129);
        rc(mci_pkg::OFF_WORD88, 32'h0000_001F, "word88 mdma");
        rc(mci_pkg::OFF_WORD163, 32'h0000_0492, "word163");
        rc(mci_pkg::OFF_WORD164, 32'h0000_8B83, "word164 mdma");
        wr(mci_pkg::OFF_CONFIG, 32'h0000_00B9);
        rc(mci_pkg::OFF_WORD163, 32'h0000_0052, "word163 clamp");
        wr(mci_pkg::OFF_CONFIG, 32'h0000_01DD);
        rc(mci_pkg::OFF_WORD88, 32'h0000_001F, "word88 kind3");
        rc(mci_pkg::OFF_WORD163, 32'h0000_0012, "word163 pio rsv");
        wr(mci_pkg::OFF_CONFIG, 32'h0000_0128);
        rc(mci_pkg::OFF_WORD88, 32'h0000_0000, "word88 off");
        wr(mci_pkg::OFF_WORD163, 32'h0000_FFFF);
        rc(mci_pkg::OFF_WORD163, 32'h0000_0492, "word163 ro");
        rc(12'h024, 32'h0000_0000, "unmapped");
        chk("slverr", {31'h0, err}, 32'h0000_0001);
        wr(mci_pkg::OFF_DRIVE_HEAD, 32'h0000_00A5);
        rc(mci_pkg::OFF_DRIVE_HEAD, 32'h0000_00A5, "drive head");
        wr(mci_pkg::OFF_XFER_COUNT, 32'h0000_0000);
        wr(mci_pkg::OFF_COMMAND, 32'h0000_0095);
        @(posedge pclk);
        chk("no busy", {31'h0, busy_flag}, 32'h0000_0000);
        wr(mci_pkg::OFF_COMMAND, {24'h00_0000, mci_pkg::OP_IDLE_A});
        wait_done();
        rc(mci_pkg::OFF_STATUS, 32'h0000_0026, "status idle");
        rc(mci_pkg::OFF_STATUS, 32'h0000_0024, "status clear");
        repeat (200) @(posedge pclk);
        cs("no autopd", 32'h0000_0000);
        wr(mci_pkg::OFF_XFER_COUNT, 32'h0000_0002);
        wr(mci_pkg::OFF_COMMAND, {24'h00_0000, mci_pkg::OP_IDLE_B});
        wait_done();
        for (int i = 0; i < 4; i++) begin
            repeat (30) @(posedge pclk);
            rc(mci_pkg::OFF_COMMAND, 32'h0000_0000, "command");
        end
        cs("restart", 32'h0000_0000);
        repeat (36) @(posedge pclk);
        cs("pd early", 32'h0000_0000);
        repeat (8) @(posedge pclk);
        cs("pd", 32'h0000_0001);
        wr(mci_pkg::OFF_DRIVE_HEAD, 32'h0000_0000);
        cs("wake", 32'h0000_0000);
        finish_test();
    end
endmodule
